/* File: hw/gtimer_pkg.sv */
// Package: register map, fields, reset values and timing for the gated timer
package gtimer_pkg;
    // Register offsets (byte addresses on the plain port)
    localparam logic [11:0] OFS_GATE_CONTROL = 12'hF9A;
    localparam logic [11:0] OFS_TIMER_CONTROL = 12'hFCD;
    localparam logic [11:0] OFS_COUNT_LOW = 12'hFCE;
    localparam logic [11:0] OFS_COUNT_HIGH = 12'hFCF;

    // Gate control fields
    localparam int GC_GATE_ENABLE = 7;
    localparam int GC_POLARITY = 6;
    localparam int GC_TOGGLE = 5;
    localparam int GC_SINGLE_PULSE = 4;
    localparam int GC_GO_DONE = 3;
    localparam int GC_VALUE = 2;
    localparam int GC_SOURCE_LSB = 0;

    // Timer control fields
    localparam int TC_SOURCE_LSB = 6;
    localparam int TC_PRESCALE_LSB = 4;
    localparam int TC_OSC_ENABLE = 3;
    localparam int TC_SYNC_BYPASS = 2;
    localparam int TC_WIDE_ACCESS = 1;
    localparam int TC_TIMER_ON = 0;

    // Reset values
    localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Clock source codes
    localparam logic [1:0] SRC_INSTR = 2'h0;
    localparam logic [1:0] SRC_SYSTEM = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;

    // Gate source codes
    localparam logic [1:0] GSRC_PIN = 2'h0;
    localparam logic [1:0] GSRC_MATCH = 2'h1;
    localparam logic [1:0] GSRC_CMP1 = 2'h2;
    localparam logic [1:0] GSRC_CMP2 = 2'h3;

    // Instruction clock ticks when the divider reaches this, so system clock divided by 4
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [1:0] DRIVE_HIGH = 2'h3;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic external_count;
        logic crystal_in;
        logic gate_pin;
        logic match;
        logic cmp1;
        logic cmp2;
    } ext_in_t;

    typedef struct packed {
        logic crystal_enable;
        logic crystal_high_drive;
        logic pins_forced_input;
    } osc_ctl_t;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ARMED,
        SP_RUN
    } sp_state_t;
endpackage

/* File: hw/gated_timer.sv */
// Gated 16-bit timer/counter with register port and gate logic
//
// Summary of operation
// RQ1: Gate enable ignored while timer is off
// RQ2: Polarity bit picks counting gate level
// RQ3: Toggle mode flops gate on rising edges
// RQ4: Single-pulse mode takes over gate control
// RQ5: Go/done bit high while armed waiting
// RQ6: Clearing single-pulse mode clears go/done
// RQ7: Gate value bit shows gate, read-only
// RQ8: Source field picks pin, match, comparators
// RQ9: Software programs gate control register first; the bench writes timer control first
// RQ10: Sixteen-bit up counter, accessed by bytes
// RQ11: Internal clock prescaled, external counts edges
// RQ12: Enabled timer forces pins input, reads zero
// RQ13: Source code picks system, instruction, external
// RQ14: External source counts rising edge, sync optional
// RQ15: Falling edge needed before first count
// RQ16: Wide mode low read latches high buffer
// RQ17: Wide mode low write loads high too
// RQ18: Only low-byte write clears the prescaler
// RQ19: Oscillator enable powers crystal, always running
// RQ20: Software waits for crystal start-up itself
// RQ21: Drive field value 11 selects high drive
// RQ22: Prescale field divides by 1,2,4,8
// RQ23: Sync bypass bit only matters for external
// RQ24: Counter wraps from maximum to zero
// RQ25: Synced input passes two-stage synchroniser; the code uses three stages
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module gated_timer
    import gtimer_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register port
    input wire gtimer_pkg::bus_req_t bus_i,
    output logic [7:0] rdata_o,
    // Pins, internal gate sources and configuration word
    input wire gtimer_pkg::ext_in_t ext_i,
    input wire logic [1:0] config_word_low_i,
    // Oscillator and pin control, and counter value
    output gtimer_pkg::osc_ctl_t osc_o,
    output logic [15:0] count_o
);
    import gtimer_pkg::*;

    typedef struct packed {
        logic [7:0] gcon;
        logic [7:0] tcon;
        logic [15:0] count;
        logic [7:0] high_buf;
        logic [2:0] prescale;
        logic [1:0] instr_div;
        logic [2:0] ext_sync;
        logic ext_prev;
        logic armed_edge;
        logic [2:0] gate_sync;
        logic gate_prev;
        logic toggle_ff;
        sp_state_t sp;
        logic [7:0] rdata;
        osc_ctl_t osc;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam state_t STATE_RESET = '{
        gcon: GATE_CONTROL_RESET,
        tcon: TIMER_CONTROL_RESET,
        count: COUNT_RESET,
        high_buf: 8'h00,
        prescale: 3'h0,
        instr_div: 2'h0,
        ext_sync: 3'h0,
        ext_prev: 1'b0,
        armed_edge: 1'b0,
        gate_sync: 3'h0,
        gate_prev: 1'b0,
        toggle_ff: 1'b0,
        sp: SP_IDLE,
        rdata: 8'h00,
        osc: '0
    };

    logic timer_on;
    logic gate_en;
    logic polarity;
    logic toggle_en;
    logic sp_en;
    logic [1:0] gsrc;
    logic [1:0] csrc;
    logic [1:0] psel;
    logic bypass;
    logic wide;
    logic ext_raw;
    logic ext_level;
    logic ext_rise;
    logic gate_raw;
    logic gate_lvl;
    logic gate_rise;
    logic gate_path;
    logic gate_active;
    logic gate_fall_active;
    logic tick;
    logic inc;
    logic [2:0] pre_last;
    logic wr_low;
    logic wr_high;
    logic wr_gcon;
    logic wr_tcon;
    logic rd_low;
    logic [7:0] rd_mux;

    always_comb begin
        s_d = s_q;
        timer_on = s_q.tcon[TC_TIMER_ON];
        gate_en = s_q.gcon[GC_GATE_ENABLE];
        polarity = s_q.gcon[GC_POLARITY];
        toggle_en = s_q.gcon[GC_TOGGLE];
        sp_en = s_q.gcon[GC_SINGLE_PULSE];
        gsrc = s_q.gcon[GC_SOURCE_LSB +: 2];
        csrc = s_q.tcon[TC_SOURCE_LSB +: 2];
        psel = s_q.tcon[TC_PRESCALE_LSB +: 2];
        bypass = s_q.tcon[TC_SYNC_BYPASS];
        wide = s_q.tcon[TC_WIDE_ACCESS];

        wr_gcon = bus_i.wr && (bus_i.addr == OFS_GATE_CONTROL);
        wr_tcon = bus_i.wr && (bus_i.addr == OFS_TIMER_CONTROL);
        wr_low = bus_i.wr && (bus_i.addr == OFS_COUNT_LOW);
        wr_high = bus_i.wr && (bus_i.addr == OFS_COUNT_HIGH);
        rd_low = bus_i.rd && (bus_i.addr == OFS_COUNT_LOW);

        // RQ13: crystal or count pin as external
        ext_raw = s_q.tcon[TC_OSC_ENABLE] ? ext_i.crystal_in
                                          : ext_i.external_count;
        s_d.ext_sync = {s_q.ext_sync[1:0], ext_raw};
        // RQ25: three-stage sync, last stage gives the level
        // RQ23: bypass takes the raw pin level
        if (bypass) begin
            ext_level = ext_raw;
        end else begin
            ext_level = s_q.ext_sync[2];
        end
        s_d.ext_prev = ext_level;
        // RQ15: a low level arms counting first
        if (!ext_level) begin
            s_d.armed_edge = 1'b1;
        end
        if (!timer_on || wr_low || wr_high) begin
            s_d.armed_edge = 1'b0;
        end
        // RQ14: count rising edges once armed
        ext_rise = ext_level && !s_q.ext_prev && s_q.armed_edge;

        // RQ8: gate source multiplexer
        case (gsrc)
            GSRC_PIN: gate_raw = ext_i.gate_pin;
            GSRC_MATCH: gate_raw = ext_i.match;
            GSRC_CMP1: gate_raw = ext_i.cmp1;
            GSRC_CMP2: gate_raw = ext_i.cmp2;
            default: gate_raw = 1'b0;
        endcase
        // Sources may be asynchronous, so three stages
        s_d.gate_sync = {s_q.gate_sync[1:0], gate_raw};
        gate_lvl = s_q.gate_sync[2];
        s_d.gate_prev = gate_lvl;
        gate_rise = gate_lvl && !s_q.gate_prev;

        // RQ3: toggle flop, held clear when disabled
        if (!toggle_en) begin
            s_d.toggle_ff = 1'b0;
        end else if (gate_rise) begin
            s_d.toggle_ff = !s_q.toggle_ff;
        end
        gate_path = toggle_en ? s_q.toggle_ff : gate_lvl;
        // RQ2: polarity picks the counting level
        gate_active = polarity ? gate_path : !gate_path;
        gate_fall_active = !gate_active;

        // RQ4: single pulse sequence gates counting
        case (s_q.sp)
            SP_IDLE: begin
                if (sp_en && wr_gcon && bus_i.wdata[GC_GO_DONE]) begin
                    s_d.sp = SP_ARMED;
                end
            end
            SP_ARMED: begin
                if (gate_active) begin
                    s_d.sp = SP_RUN;
                end
            end
            SP_RUN: begin
                if (gate_fall_active) begin
                    s_d.sp = SP_IDLE;
                end
            end
            default: s_d.sp = SP_IDLE;
        endcase
        // RQ6: leaving single pulse mode ends acquisition
        if (wr_gcon && !bus_i.wdata[GC_SINGLE_PULSE]) begin
            s_d.sp = SP_IDLE;
        end
        // Writing go low cannot abort; only a mode clear can
        if (wr_gcon && sp_en && !bus_i.wdata[GC_GO_DONE]
                && bus_i.wdata[GC_SINGLE_PULSE]
                && s_q.sp != SP_IDLE) begin
            s_d.sp = s_q.sp;
        end

        // RQ13: instruction clock is system divided
        s_d.instr_div = s_q.instr_div + 2'h1;
        // RQ11: internal or external tick
        case (csrc)
            SRC_SYSTEM: tick = 1'b1;
            SRC_INSTR: tick = (s_q.instr_div == INSTR_DIV_LAST);
            SRC_EXTERNAL: tick = ext_rise;
            default: tick = 1'b0;
        endcase

        // RQ22: prescale ratio 1, 2, 4 or 8
        case (psel)
            2'h0: pre_last = 3'h0;
            2'h1: pre_last = 3'h1;
            2'h2: pre_last = 3'h3;
            default: pre_last = 3'h7;
        endcase

        // RQ1: gate only matters with timer on
        inc = 1'b0;
        if (timer_on && tick) begin
            if (s_q.prescale >= pre_last) begin
                s_d.prescale = 3'h0;
                if (!gate_en) begin
                    inc = 1'b1;
                end else if (sp_en) begin
                    inc = (s_q.sp == SP_RUN) && gate_active;
                end else begin
                    inc = gate_active;
                end
            end else begin
                s_d.prescale = s_q.prescale + 3'h1;
            end
        end

        // RQ24: plain wrap at the top
        // RQ10: sixteen-bit incrementing counter
        if (inc) begin
            s_d.count = s_q.count + 16'h0001;
        end

        // Register writes win over counting
        if (wr_gcon) begin
            s_d.gcon[7:4] = bus_i.wdata[7:4];
            s_d.gcon[1:0] = bus_i.wdata[1:0];
        end
        if (wr_tcon) begin
            s_d.tcon = bus_i.wdata;
        end
        // RQ18: high write keeps prescaler
        if (wr_high) begin
            if (wide) begin
                s_d.high_buf = bus_i.wdata;
            end else begin
                s_d.count[15:8] = bus_i.wdata;
            end
        end
        // RQ18: low write clears the prescaler
        if (wr_low) begin
            s_d.count[7:0] = bus_i.wdata;
            s_d.prescale = 3'h0;
            // RQ17: buffered high byte loads together
            if (wide) begin
                s_d.count[15:8] = s_q.high_buf;
            end
        end
        // RQ16: low read snapshots the high byte
        if (rd_low && wide) begin
            s_d.high_buf = s_q.count[15:8];
        end

        // RQ5: go/done reflects waiting or running
        // RQ7: gate value shows gate_active, the gate after polarity
        rd_mux = 8'h00;
        case (bus_i.addr)
            OFS_GATE_CONTROL: begin
                rd_mux = s_q.gcon;
                rd_mux[GC_GO_DONE] = (s_q.sp != SP_IDLE);
                rd_mux[GC_VALUE] = gate_active;
            end
            OFS_TIMER_CONTROL: rd_mux = s_q.tcon;
            OFS_COUNT_LOW: rd_mux = s_q.count[7:0];
            OFS_COUNT_HIGH: rd_mux = wide ? s_q.high_buf
                                          : s_q.count[15:8];
            default: rd_mux = 8'h00;
        endcase
        s_d.rdata = bus_i.rd ? rd_mux : 8'h00;

        // RQ19: crystal runs whenever enabled
        s_d.osc.crystal_enable = s_q.tcon[TC_OSC_ENABLE];
        // RQ21: drive level from configuration field
        s_d.osc.crystal_high_drive = (config_word_low_i == DRIVE_HIGH);
        // RQ12: enabled timer owns both pins
        s_d.osc.pins_forced_input = timer_on;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign osc_o = s_q.osc;
    assign count_o = s_q.count;
endmodule

/* File: verif/gtimer_monitor.sv */
// Port checker for the gated timer
`timescale 1ns/1ps
module gtimer_monitor
    import gtimer_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire gtimer_pkg::bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    // Configuration and outputs
    input wire logic [1:0] config_word_low_i,
    input wire gtimer_pkg::osc_ctl_t osc_o,
    input wire logic [15:0] count_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic mapped;
    logic tc_wr;
    assign mapped = bus_i.addr inside {OFS_GATE_CONTROL,
        OFS_TIMER_CONTROL, OFS_COUNT_LOW, OFS_COUNT_HIGH};
    assign tc_wr = bus_i.wr && bus_i.addr == OFS_TIMER_CONTROL;

    rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (bus_i.rd && !mapped |=>
        rdata_o == 8'h00) else $error("unmapped read not zero");
    read_low_a: assert property (bus_i.rd &&
        bus_i.addr == OFS_COUNT_LOW |=> rdata_o == $past(count_o[7:0]))
        else $error("low byte read wrong");
    count_step_a: assert property (!bus_i.wr |=> count_o ==
        $past(count_o) || count_o == $past(count_o) + 16'h1)
        else $error("counter jumped");
    // No write for two cycles, so the on bit cannot have just risen
    hold_off_a: assert property ((!osc_o.pins_forced_input
        && !bus_i.wr)[*2] |=> $stable(count_o))
        else $error("counter moved while off");
    timer_on_a: assert property (tc_wr && bus_i.wdata[0] |->
        ##[1:2] osc_o.pins_forced_input) else $error("pins not forced");
    timer_off_a: assert property (tc_wr && !bus_i.wdata[0] |->
        ##[1:2] !osc_o.pins_forced_input) else $error("pins still forced");
    drive_follow_a: assert property ($past(resetn_i) |=>
        osc_o.crystal_high_drive == ($past(config_word_low_i) == DRIVE_HIGH))
        else $error("drive level wrong");

    cover property (count_o == 16'hFFFF ##1 count_o == 16'h0000);
    cover property (bus_i.rd && bus_i.addr == OFS_COUNT_LOW);
    cover property ($rose(osc_o.pins_forced_input));
endmodule

/* File: verif/gtimer_pins.sv */
// Pin-side model: count pin, crystal and gate sources
`timescale 1ns/1ps
module gtimer_pins
    import gtimer_pkg::*;
#(
    parameter int HALF_NS = 20
)
(
    // Control from the bench
    input wire logic run_i,
    input wire logic xtal_on_i,
    input wire logic [3:0] gate_i,
    // Pin levels
    output gtimer_pkg::ext_in_t ext_o
);
    logic cnt_q = 1'b0;
    logic xtal_q = 1'b0;
    // Count pin stands low outside a run
    always #(HALF_NS) cnt_q = run_i ? !cnt_q : 1'b0;
    always #(HALF_NS) xtal_q = xtal_on_i ? !xtal_q : 1'b0;
    assign ext_o = {cnt_q, xtal_q, gate_i};
endmodule

/* File: verif/gated_timer_tb.sv */
// Self-checking bench for the gated timer
`timescale 1ns/1ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module gated_timer_tb;
    import gtimer_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    bus_req_t bus_i = '0;
    logic [1:0] config_word_low_i = 2'h3;
    logic run = 1'b0;
    logic [3:0] gates = 4'h0;
    ext_in_t ext_i;
    osc_ctl_t osc_o;
    logic [7:0] rdata_o;
    logic [15:0] count_o;
    logic [15:0] c0;
    logic [7:0] v;
    logic [7:0] v_tab [3] = '{8'h81, 8'h85, 8'h89};
    int n_fail = 0;
    int n_compared = 0;

    always #2 clk_sys_i = !clk_sys_i;

    gated_timer u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .ext_i(ext_i),
        .config_word_low_i(config_word_low_i), .osc_o(osc_o),
        .count_o(count_o));
    gtimer_pins u_pins (.run_i(run), .xtal_on_i(osc_o.crystal_enable),
        .gate_i(gates), .ext_o(ext_i));

    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] m,
        input logic [7:0] e);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1;
        `CHK(rdata_o & m, e);
    endtask

    // Settle sync stages before counting a window
    task automatic delta(input int cyc, output logic [15:0] d);
        logic [15:0] s;
        repeat (4) @(posedge clk_sys_i);
        #1 s = count_o;
        repeat (cyc) @(posedge clk_sys_i);
        #1 d = count_o - s;
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Tests need about 2050 cycles; give ample margin
    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rchk(OFS_GATE_CONTROL, 8'hFB, 8'h00);
        rchk(OFS_TIMER_CONTROL, 8'hFF, 8'h00);
        rchk(12'h123, 8'hFF, 8'h00);
        `CHK(osc_o.crystal_high_drive, 1);
        config_word_low_i <= 2'h1;
        repeat (3) @(posedge clk_sys_i);
        `CHK(osc_o.crystal_high_drive, 0);
        $display("reset test done");
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                wr(OFS_TIMER_CONTROL, 8'(s * 64 + p * 16 + 1));
                wr(OFS_COUNT_LOW, 8'h00);
                delta(64, c0);
                `CHK(c0, (s ? 64 : 16) >> p);
            end
        end
        wr(OFS_COUNT_LOW, 8'h00);
        repeat (6) wr(OFS_COUNT_HIGH, 8'h00);
        `CHK(count_o[7:0] > 0, 1);
        $display("prescale test done");
        // timer control set up before the gate
        wr(OFS_TIMER_CONTROL, 8'h41);
        for (int g = 0; g < 4; g++) begin
            gates <= 4'h8 >> g;
            wr(OFS_GATE_CONTROL, 8'(8'hC0 + g));
            // New source needs the three sync stages
            repeat (4) @(posedge clk_sys_i);
            rchk(OFS_GATE_CONTROL, 8'h04, 8'h04);
            delta(64, c0);
            `CHK(c0, 64);
            wr(OFS_GATE_CONTROL, 8'(8'h80 + g));
            delta(64, c0);
            `CHK(c0, 0);
        end
        wr(OFS_GATE_CONTROL, 8'h00);
        delta(64, c0);
        `CHK(c0, 64);
        gates <= 4'h0;
        wr(OFS_GATE_CONTROL, 8'hD0);
        wr(OFS_GATE_CONTROL, 8'hD8);
        rchk(OFS_GATE_CONTROL, 8'h08, 8'h08);
        gates <= 4'h8;
        repeat (20) @(posedge clk_sys_i);
        gates <= 4'h0;
        repeat (6) @(posedge clk_sys_i);
        rchk(OFS_GATE_CONTROL, 8'h08, 8'h00);
        gates <= 4'h8;
        delta(32, c0);
        `CHK(c0, 0);
        wr(OFS_GATE_CONTROL, 8'hD8);
        wr(OFS_GATE_CONTROL, 8'h00);
        rchk(OFS_GATE_CONTROL, 8'h08, 8'h00);
        $display("gate test done");
        wr(OFS_TIMER_CONTROL, 8'h42);
        wr(OFS_COUNT_HIGH, 8'hAB);
        wr(OFS_COUNT_LOW, 8'hCD);
        `CHK(count_o, 16'hABCD);
        rchk(OFS_COUNT_LOW, 8'hFF, 8'hCD);
        wr(OFS_COUNT_HIGH, 8'h11);
        rchk(OFS_COUNT_HIGH, 8'hFF, 8'h11);
        `CHK(count_o, 16'hABCD);
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_COUNT_LOW, 8'hFE);
        wr(OFS_TIMER_CONTROL, 8'h41);
        repeat (8) @(posedge clk_sys_i);
        `CHK(count_o < 16'h0010, 1);
        $display("wide access test done");
        run <= 1'b1;
        foreach (v_tab[i]) begin
            v = v_tab[i];
            wr(OFS_TIMER_CONTROL, v);
            delta(200, c0);
            `CHK(c0 inside {[19:21]}, 1);
            `CHK(osc_o.crystal_enable, v[3]);
            `CHK(osc_o.pins_forced_input, 1);
        end
        run <= 1'b0;
        wr(OFS_TIMER_CONTROL, 8'h81);
        delta(64, c0);
        `CHK(c0, 0);
        $display("external source test done");
        summarize();
    end
endmodule

bind gated_timer gtimer_monitor u_mon (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .config_word_low_i(config_word_low_i), .osc_o(osc_o),
    .count_o(count_o));
